//--- core/power_path_fault_supervisor.sv
// power-path switch control and fault supervision
// assumes comparator results arrive as levels from analog front end
`include "power_path_params.svh"
`timescale 1ns/1ns
// How it works
// - enable high keeps switch open, protections off except the reverse-current guard, low-power state.
// - enable low arms protections and lets the switch close without faults.
// - undriven enable is pulled low by the pad, so it reads as enabled.
// - every turn-on waits 15 ms debounce, then starts soft-start.
// - enabled with rail under undervoltage release keeps switch open.
// - above undervoltage and fault-free, switch follows enable unless small reverse is seen during debounce.
// - overvoltage opens switch; conduction resumes once rail drops.
// - threshold input under 0.1 V selects default 23 V overvoltage level.
// - over 140 C opens switch; control returns below 115 C.
// - rail under 2.5 V keeps switch open, power-good released; lockout reported only while enabled.
// - enable high keeps switch open and power-good released.
// - overvoltage keeps switch open and power-good released.
// - power-good pulled low only when fault-free and conducting.
// - reverse-current guard runs regardless of enable.
// - small reverse lasting 3.7 ms opens the switch.
// - large reverse opens the switch at once.
// - small reverse during debounce blocks turn-on.
// - guard active holds switch open and power-good released.
module power_path_fault_supervisor
  import power_path_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = `START_DEBOUNCE_CYC,
  parameter int unsigned DEGLITCH_CYC = `RCG_DEGLITCH_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // enable, active low, pad holds pull-down
  input wire logic enable_n,
  // comparator results
  input wire logic uv_low,
  input wire logic ov_high,
  input wire logic ot_high,
  input wire logic ot_low,
  input wire logic rev_small,
  input wire logic rev_big,
  // pass switch and soft-start
  output logic switch_on,
  output logic soft_start,
  // power-good open drain: output and enable
  output logic power_good_o,
  output logic power_good_oe,
  // state reporting
  output logic lockout,
  output logic guard_active,
  output logic low_power
);
  // ----------------------------------------
  // input synchronisation
  // ----------------------------------------
  sense_t raw;
  sense_t s;
  always_comb begin
    raw.enable_n = enable_n;
    raw.uv_low = uv_low;
    raw.ov_high = ov_high;
    raw.ot_high = ot_high;
    raw.ot_low = ot_low;
    raw.rev_small = rev_small;
    raw.rev_big = rev_big;
  end

  sense_sync u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .raw(raw),
    .synced(s)
  );

  // ----------------------------------------
  // counter helpers
  // ----------------------------------------
  // debounce and deglitch share these
  // true once a counter has reached its last count
  function automatic logic count_done(
    input logic [`CNT_W-1:0] cnt,
    input int unsigned limit
  );
    if (cnt >= `CNT_W'(limit - 1)) begin
      count_done = 1'b1;
    end else begin
      count_done = 1'b0;
    end
  endfunction

  // one step up, held at the top
  function automatic logic [`CNT_W-1:0] count_step(
    input logic [`CNT_W-1:0] cnt
  );
    if (cnt == {`CNT_W{1'b1}}) begin
      count_step = cnt;
    end else begin
      count_step = cnt + `CNT_W'(1);
    end
  endfunction

  // ----------------------------------------
  // enable decode
  // ----------------------------------------
  logic enabled;
  logic disabled;

  // undriven pin is pulled low in the pad, so it reads as asserted
  assign enabled = !s.enable_n;
  assign disabled = s.enable_n;

  // ----------------------------------------
  // thermal latch
  // ----------------------------------------
  logic ot_q;
  logic ot_d;

  // trip high, release low; cleared while disabled
  always_comb begin
    ot_d = ot_q;
    if (disabled) begin
      ot_d = 1'b0;
    end else if (s.ot_high) begin
      ot_d = 1'b1;
    end else if (s.ot_low) begin
      ot_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ot_q <= 1'b0;
    end else begin
      ot_q <= ot_d;
    end
  end

  // ----------------------------------------
  // reverse-current guard
  // ----------------------------------------
  logic guard_q;
  logic guard_d;
  logic [`CNT_W-1:0] dg_q;
  logic [`CNT_W-1:0] dg_d;

  // runs whatever the enable level
  // small reverse must persist through the whole deglitch
  always_comb begin
    guard_d = guard_q;
    dg_d = dg_q;
    if (s.rev_big) begin
      guard_d = 1'b1;
      dg_d = '0;
    end else if (s.rev_small) begin
      if (count_done(dg_q, DEGLITCH_CYC)) begin
        guard_d = 1'b1;
      end else begin
        dg_d = count_step(dg_q);
      end
    end else begin
      guard_d = 1'b0;
      dg_d = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      guard_q <= 1'b0;
      dg_q <= '0;
    end else begin
      guard_q <= guard_d;
      dg_q <= dg_d;
    end
  end

  // ----------------------------------------
  // fault summary
  // ----------------------------------------
  logic uv_fault;
  logic ov_fault;
  logic ot_fault;
  logic rev_fault;
  logic fault;

  assign uv_fault = s.uv_low;
  // comparator already applies the default 23 V level below 0.1 V
  assign ov_fault = s.ov_high;
  // next-state views, so a fresh trip opens the switch in the same cycle
  assign ot_fault = ot_d;
  assign rev_fault = guard_d;
  assign fault = uv_fault || ov_fault || ot_fault || rev_fault;

  // ----------------------------------------
  // switch sequencer
  // ----------------------------------------
  sw_state_t st_q;
  sw_state_t st_d;
  logic [`CNT_W-1:0] db_q;
  logic [`CNT_W-1:0] db_d;
  logic rev_seen;

  assign rev_seen = s.rev_small;

  // any fault or small reverse restarts the debounce
  always_comb begin
    st_d = st_q;
    db_d = db_q;
    unique case (st_q)
      ST_OFF: begin
        db_d = '0;
        if (enabled && !fault) begin
          st_d = ST_DEBOUNCE;
        end
      end
      ST_DEBOUNCE: begin
        if (!enabled || fault || rev_seen) begin
          st_d = ST_OFF;
          db_d = '0;
        end else if (count_done(db_q, DEBOUNCE_CYC)) begin
          st_d = ST_ON;
        end else begin
          db_d = count_step(db_q);
        end
      end
      ST_ON: begin
        if (!enabled || fault) begin
          st_d = ST_OFF;
        end
      end
      // unused code falls back to off
      default: begin
        st_d = ST_OFF;
        db_d = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_q <= ST_OFF;
      db_q <= '0;
    end else begin
      st_q <= st_d;
      db_q <= db_d;
    end
  end

  // ----------------------------------------
  // switch outputs
  // ----------------------------------------
  logic switch_on_d;
  logic soft_start_d;
  logic pg_oe_d;

  always_comb begin
    switch_on_d = (st_d == ST_ON);
    soft_start_d = switch_on_d && (st_q != ST_ON);
    pg_oe_d = switch_on_d && !fault;
  end

  // open drain: the pin is only ever pulled low
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      switch_on <= 1'b0;
      soft_start <= 1'b0;
      power_good_o <= 1'b0;
      power_good_oe <= 1'b0;
    end else begin
      switch_on <= switch_on_d;
      soft_start <= soft_start_d;
      power_good_o <= 1'b0;
      power_good_oe <= pg_oe_d;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  logic lockout_d;
  logic guard_active_d;
  logic low_power_d;

  // lockout reported only while enabled
  always_comb begin
    lockout_d = enabled && uv_fault;
    guard_active_d = guard_d;
    low_power_d = disabled;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lockout <= 1'b0;
      guard_active <= 1'b0;
      low_power <= 1'b1;
    end else begin
      lockout <= lockout_d;
      guard_active <= guard_active_d;
      low_power <= low_power_d;
    end
  end
endmodule

//--- core/power_path_params.svh
// timing counts and defaults for the power-path supervisor
// assumes a 25 MHz ref_clk; included by bare name
`ifndef POWER_PATH_PARAMS_SVH
`define POWER_PATH_PARAMS_SVH
`define CLK_FREQ_HZ 25000000
`define START_DEBOUNCE_US 15000
`define RCG_DEGLITCH_US 3700
`define START_DEBOUNCE_CYC (`START_DEBOUNCE_US * (`CLK_FREQ_HZ / 1000000))
`define RCG_DEGLITCH_CYC (`RCG_DEGLITCH_US * (`CLK_FREQ_HZ / 1000000))
`define CNT_W 20
`define SYNC_W 7
`endif

//--- core/power_path_pkg.sv
// types for the power-path supervisor
// assumes the params header is on the include path
package power_path_pkg;
  typedef struct packed {
    logic enable_n;
    logic uv_low;
    logic ov_high;
    logic ot_high;
    logic ot_low;
    logic rev_small;
    logic rev_big;
  } sense_t;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_DEBOUNCE = 2'b01,
    ST_ON = 2'b11
  } sw_state_t;
endpackage

//--- core/sense_sync.sv
// two-flop synchroniser for the comparator bundle
// assumes asynchronous comparator levels
`timescale 1ns/1ns
module sense_sync
  import power_path_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // raw and synchronised comparators
  input wire sense_t raw,
  output sense_t synced
);
  sense_t meta_q;
  sense_t meta_d;
  sense_t sync_q;
  sense_t sync_d;
  // a disabled, undervoltaged idle value
  localparam sense_t IDLE = '{enable_n: 1'b1, uv_low: 1'b1, default: 1'b0};

  always_comb begin
    meta_d = raw;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_q <= IDLE;
      sync_q <= IDLE;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign synced = sync_q;
endmodule

//--- verification/pps_asserts.sv
// assertions on the supervisor ports
// bound into every supervisor instance
`timescale 1ns/1ns
module pps_asserts #(
  parameter int unsigned DEBOUNCE_CYC = 20,
  parameter int unsigned DEGLITCH_CYC = 10
) (
  input wire logic ref_clk, resetn, enable_n, uv_low, ov_high, ot_high, rev_small,
  input wire logic rev_big, switch_on, soft_start, power_good_o, power_good_oe,
  input wire logic lockout, guard_active, low_power
);
  logic [31:0] ok_q;
  logic ok;
  assign ok = !enable_n && !uv_low && !ov_high && !ot_high && !rev_small && !rev_big;
  always_ff @(posedge ref_clk) ok_q <= (ok && resetn) ? ok_q + 32'h1 : 32'h0;
  default clocking c @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_off; enable_n [*6] |-> !switch_on && low_power; endproperty
  a_off: assert property (p_off) else $error("switch on while disabled");
  property p_pg; power_good_oe |-> switch_on && !lockout && !guard_active && !power_good_o;
  endproperty
  a_pg: assert property (p_pg) else $error("power good without conduction");
  property p_ss; $rose(switch_on) |-> soft_start ##1 !soft_start; endproperty
  a_ss: assert property (p_ss) else $error("soft start pulse wrong");
  property p_deb; $rose(switch_on) |-> $past(ok_q, 2) >= DEBOUNCE_CYC; endproperty
  a_deb: assert property (p_deb) else $error("turn-on before debounce");
  property p_uv; (!enable_n && uv_low) [*6] |-> lockout && !switch_on; endproperty
  a_uv: assert property (p_uv) else $error("lockout missing");
  property p_ov; ov_high [*6] |-> !switch_on && !power_good_oe; endproperty
  a_ov: assert property (p_ov) else $error("switch on in overvoltage");
  property p_ot; ot_high [*6] |-> !switch_on; endproperty
  a_ot: assert property (p_ot) else $error("switch on when hot");
  property p_big; rev_big [*6] |-> guard_active && !switch_on; endproperty
  a_big: assert property (p_big) else $error("guard missing");
endmodule
bind power_path_fault_supervisor pps_asserts #(.DEBOUNCE_CYC(DEBOUNCE_CYC),
  .DEGLITCH_CYC(DEGLITCH_CYC)) chk_u (.ref_clk(ref_clk), .resetn(resetn),
  .enable_n(enable_n), .uv_low(uv_low), .ov_high(ov_high), .ot_high(ot_high),
  .rev_small(rev_small), .rev_big(rev_big), .switch_on(switch_on), .soft_start(soft_start),
  .power_good_o(power_good_o), .power_good_oe(power_good_oe), .lockout(lockout),
  .guard_active(guard_active), .low_power(low_power));

//--- verification/rail_model.sv
// system side: enable pad and power-good pin
// pull-down on enable, pull-up on power-good
`timescale 1ns/1ns
module rail_model (
  // enable pad
  input wire logic en_drv,
  input wire logic en_val,
  output logic enable_n,
  // power-good pin
  input wire logic power_good_o,
  input wire logic power_good_oe,
  output logic pg_pin
);
  assign enable_n = en_drv ? en_val : 1'b0;
  assign pg_pin = power_good_oe ? power_good_o : 1'b1;
endmodule

//--- verification/tb.sv
// self-checking bench for the supervisor
// short debounce and deglitch counts
`timescale 1ns/1ns
module tb;
  localparam int D = 20;
  logic ref_clk = 0, resetn = 0, en_drv = 1, en_val = 1, rev_small = 0;
  logic [3:0] f = 4'h0;
  logic enable_n, switch_on, soft_start, pg_o, pg_oe, pg_pin, lockout, guard_active, low_power;
  int n_mismatch = 0, n_compared = 0, cyc = 0, n;
  initial forever #20 ref_clk = ~ref_clk;
  rail_model rm_u (.en_drv(en_drv), .en_val(en_val), .enable_n(enable_n),
    .power_good_o(pg_o), .power_good_oe(pg_oe), .pg_pin(pg_pin));
  power_path_fault_supervisor #(.DEBOUNCE_CYC(D), .DEGLITCH_CYC(10)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .enable_n(enable_n), .uv_low(f[0]),
    .ov_high(f[1]), .ot_high(f[2]), .ot_low(~f[2]), .rev_small(rev_small), .rev_big(f[3]),
    .switch_on(switch_on), .soft_start(soft_start), .power_good_o(pg_o),
    .power_good_oe(pg_oe), .lockout(lockout), .guard_active(guard_active),
    .low_power(low_power));
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cy(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic run_to(input logic v);
    n = 0;
    while (switch_on !== v && n < 200) begin
      cy(1);
      n++;
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d, wrong %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_on;
    @(posedge ref_clk) en_drv <= 0;
    run_to(1);
    chk(n inside {[D:D+6]}, 1);
    chk({soft_start, pg_pin}, 2'h2);
    @(posedge ref_clk) en_drv <= 1;
    run_to(0);
    cy(2);
    chk({n <= 6, pg_pin, low_power}, 3'h7);
    $display("t_on done");
  endtask
  task automatic t_faults;
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk) en_val <= 0;
      run_to(1);
      @(posedge ref_clk) f <= 4'h1 << k;
      run_to(0);
      chk({n <= 6, pg_pin, lockout, guard_active}, {2'h3, k == 0, k == 3});
      cy(4);
      @(posedge ref_clk) f <= 4'h0;
      run_to(1);
      chk(n >= D, 1);
      @(posedge ref_clk) en_val <= 1;
      run_to(0);
    end
    $display("t_faults done");
  endtask
  task automatic t_rev;
    @(posedge ref_clk) en_val <= 0;
    run_to(1);
    @(posedge ref_clk) rev_small <= 1;
    run_to(0);
    chk(n inside {[10:16]}, 1);
    @(posedge ref_clk) en_val <= 1;
    rev_small <= 0;
    f <= 4'h8;
    cy(8);
    chk(guard_active, 1);
    @(posedge ref_clk) f <= 4'h0;
    $display("t_rev done");
  endtask
  task automatic t_start;
    @(posedge ref_clk) en_val <= 0;
    cy(5);
    @(posedge ref_clk) rev_small <= 1;
    cy(3);
    @(posedge ref_clk) rev_small <= 0;
    run_to(1);
    chk(n >= D, 1);
    @(posedge ref_clk) en_val <= 1;
    run_to(0);
    $display("t_start done");
  endtask
  initial begin
    cy(6);
    @(posedge ref_clk) resetn <= 1;
    cy(1);
    chk({switch_on, low_power}, 2'h1);
    t_on;
    t_faults;
    t_rev;
    t_start;
    print_verdict;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict;
    end
  end
endmodule
